// *** ppo_far_side.sv ***
// far side model: one alternate-function module and the external pad drivers
`timescale 1ns/1ps
module ppo_far_side (
  // clock
  input  wire logic                          i_sys_clk,
  // alternate-function side
  input  wire logic                          i_alt_active,
  input  wire ppo_pkg::ppo_override_type     i_alt_vals,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_alt_fn_raw_input,
  output ppo_pkg::ppo_override_type          o_override,
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_alt_sync,
  // pad ring and external drivers
  input  wire ppo_pkg::ppo_pad_ctrl_type     i_pad_ctrl,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_ext_en,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_ext_val,
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_pad
);
  logic [ppo_pkg::PIN_COUNT-1:0] meta_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] last_pad_reg = '0;
  // overrides made here, all low while idle
  assign o_override = i_alt_active ? i_alt_vals : '0;
  // own two-flop synchroniser, the raw input is unsynchronised
  always_ff @(posedge i_sys_clk) begin
    meta_reg     <= i_alt_fn_raw_input;
    o_alt_sync   <= meta_reg;
    last_pad_reg <= o_pad;
  end
  // pad level: driver, external, pull-up; a floating pin drifts every cycle
  always_comb begin
    for (int i = 0; i < ppo_pkg::PIN_COUNT; i++) begin
      if (i_pad_ctrl.drive_en[i])
        o_pad[i] = i_pad_ctrl.drive_val[i];
      else if (i_ext_en[i])
        o_pad[i] = i_ext_val[i];
      else if (i_pad_ctrl.pullup_en[i])
        o_pad[i] = 1'h1;
      else
        o_pad[i] = ~last_pad_reg[i];
    end
  end
endmodule // ppo_far_side

// *** ppo_pin_sync.sv ***
// input synchronizer for one port: three flops, change taken when the last two agree
`timescale 1ns/1ps
module ppo_pin_sync (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  // raw gated pad input
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_raw,
  // filtered, synchronised value
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_sync
);
  logic [ppo_pkg::PIN_COUNT-1:0] meta_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] s2_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] s3_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] sync_reg;

  // three-stage chain; first stage read only by the second
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
    end else begin
      meta_reg <= i_raw;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // accept a bit only once stages two and three agree, filtering one-cycle glitches
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync_reg <= {ppo_pkg::PIN_COUNT{ppo_pkg::RST_PIN}};
    end else begin
      for (int i = 0; i < ppo_pkg::PIN_COUNT; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign o_sync = sync_reg;
endmodule // ppo_pin_sync

// *** ppo_pkg.sv ***
// package for the port pin override logic: widths, reset values, carriers
package ppo_pkg;
  // pins per port
  localparam int PIN_COUNT = 8;
  // register bit reset values
  localparam logic RST_DIR  = 1'h0;
  localparam logic RST_DATA = 1'h0;
  localparam logic RST_PIN  = 1'h0;
  // sleep clamp forces this level ahead of the input stage
  localparam logic CLAMP_LEVEL = 1'h0;
  // external interrupt sense encodings
  localparam logic [1:0] SENSE_LOW     = 2'h0;
  localparam logic [1:0] SENSE_ANY     = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING  = 2'h3;

  // per-pin override bundle from the alternate-function modules
  typedef struct packed {
    logic [PIN_COUNT-1:0] pullup_override_enable;
    logic [PIN_COUNT-1:0] pullup_override_value;
    logic [PIN_COUNT-1:0] direction_override_enable;
    logic [PIN_COUNT-1:0] direction_override_value;
    logic [PIN_COUNT-1:0] port_value_override_enable;
    logic [PIN_COUNT-1:0] port_value_override_value;
    logic [PIN_COUNT-1:0] input_enable_override_enable;
    logic [PIN_COUNT-1:0] input_enable_override_value;
  } ppo_override_type;

  // per-pin pad controls toward the pad ring
  typedef struct packed {
    logic [PIN_COUNT-1:0] drive_en;
    logic [PIN_COUNT-1:0] drive_val;
    logic [PIN_COUNT-1:0] pullup_en;
  } ppo_pad_ctrl_type;
endpackage

// *** ppo_port.sv ***
// one eight-pin I/O port with alternate-function override and sleep clamp
`timescale 1ns/1ps
// Functional notes
// - sleep clamp forces every digital input without interrupt bypass or input-enable override to ground before the input stage
// - no clamp outside the deep sleep modes
// - external interrupt pins skip the clamp while their request is enabled
// - disabled external interrupt pins are clamped like ordinary pins
// - clamp release sets flag of disabled edge-sensed async interrupt whose pin is high
// - all pull-ups off while reset is active
// - pull-up override enable selects pull-up from override value alone
// - otherwise pull-up on only for direction 0, data 1, global disable 0
// - driver enable from direction override value, else direction bit
// - driven value from value override when enabled, else data bit
// - input-enable override decides input enable, else sleep state and interrupt bypass decide
// - alternate functions get the raw input before the port synchronizer
// - strobes shared per port, clock, clamp, global disable shared, overrides per pin
// - analog path connects straight to the pad, both directions
// - direction bit one makes an output, zero an input
// - global pull-up disable turns off all pull-ups except those under pull-up override
// - all pins tri-stated at the first clock edge with reset active
// - pin input passes a three-stage synchroniser before software reads it
module ppo_port (
  // clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  // shared port controls
  input  wire logic                          i_sleep_clamp,
  input  wire logic                          i_global_pullup_disable,
  // register strobes and data bus
  input  wire logic                          i_write_output_data_strobe,
  input  wire logic                          i_write_direction_strobe,
  input  wire logic                          i_read_output_data_strobe,
  input  wire logic                          i_read_direction_strobe,
  input  wire logic                          i_read_pin_strobe,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_wdata,
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_rdata,
  // alternate-function overrides and inputs
  input  wire ppo_pkg::ppo_override_type     i_override,
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_alt_fn_raw_input,
  // external interrupt pins
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_ext_int_pin,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_ext_int_enable,
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_ext_int_async,
  input  wire logic [1:0]                    i_ext_int_sense [ppo_pkg::PIN_COUNT],
  output logic      [ppo_pkg::PIN_COUNT-1:0] o_ext_int_wake_set,
  // pads
  input  wire logic [ppo_pkg::PIN_COUNT-1:0] i_pad,
  output ppo_pkg::ppo_pad_ctrl_type          o_pad_ctrl
);
  logic [ppo_pkg::PIN_COUNT-1:0] pin_direction_bit_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] pin_output_data_bit_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] pin_input_sample_bit;
  logic [ppo_pkg::PIN_COUNT-1:0] in_enable;
  logic [ppo_pkg::PIN_COUNT-1:0] gated_in;
  logic [ppo_pkg::PIN_COUNT-1:0] drv_en_next;
  logic [ppo_pkg::PIN_COUNT-1:0] drv_val_next;
  logic [ppo_pkg::PIN_COUNT-1:0] pu_next;
  logic [ppo_pkg::PIN_COUNT-1:0] wake_next;
  logic                          sleep_d_reg;
  ppo_pkg::ppo_pad_ctrl_type     pad_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] rdata_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] raw_reg;
  logic [ppo_pkg::PIN_COUNT-1:0] wake_reg;

  // sense codes that arm the clamp-release flag
  function automatic logic edge_sense(input logic [1:0] s);
    return (s == ppo_pkg::SENSE_ANY) || (s == ppo_pkg::SENSE_FALLING) ||
           (s == ppo_pkg::SENSE_RISING);
  endfunction

  // direction and data registers, shared port strobes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_direction_bit_reg   <= {ppo_pkg::PIN_COUNT{ppo_pkg::RST_DIR}};
      pin_output_data_bit_reg <= {ppo_pkg::PIN_COUNT{ppo_pkg::RST_DATA}};
    end else begin
      if (i_write_direction_strobe) begin
        pin_direction_bit_reg <= i_wdata;
      end
      if (i_write_output_data_strobe) begin
        pin_output_data_bit_reg <= i_wdata;
      end
    end
  end

  // per-pin override muxing; each pin has its own override set
  genvar g;
  generate
    for (g = 0; g < ppo_pkg::PIN_COUNT; g++) begin : g_pin
      assign drv_en_next[g] = i_override.direction_override_enable[g] ?
                              i_override.direction_override_value[g] :
                              pin_direction_bit_reg[g];
      assign drv_val_next[g] = i_override.port_value_override_enable[g] ?
                               i_override.port_value_override_value[g] :
                               pin_output_data_bit_reg[g];
      // override pull-up; otherwise 0-1-0 pattern only
      // register path also yields to a forced driver, so the two never fight
      assign pu_next[g] = i_override.pullup_override_enable[g] ?
                          i_override.pullup_override_value[g] :
                          (({pin_direction_bit_reg[g], pin_output_data_bit_reg[g],
                             i_global_pullup_disable} == 3'h2) && !drv_en_next[g]);
      // input enable; clamp only in sleep; interrupt bypass
      assign in_enable[g] = i_override.input_enable_override_enable[g] ?
                            i_override.input_enable_override_value[g] :
                            (!i_sleep_clamp ||
                             (i_ext_int_pin[g] && i_ext_int_enable[g]));
      assign gated_in[g] = in_enable[g] ? i_pad[g] : ppo_pkg::CLAMP_LEVEL;
      // clamp release on a high, disabled, edge-sensed async pin
      assign wake_next[g] = sleep_d_reg && !i_sleep_clamp && i_ext_int_pin[g] &&
                            i_ext_int_async[g] && !i_ext_int_enable[g] &&
                            i_pad[g] && edge_sense(i_ext_int_sense[g]);
    end
  endgenerate

  // pad controls registered; reset tri-states and drops pull-ups
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pad_reg <= '0;
    end else begin
      pad_reg.drive_en  <= drv_en_next;
      pad_reg.drive_val <= drv_val_next;
      pad_reg.pullup_en <= pu_next;
    end
  end

  // raw gated input to alternate functions, not synchronised here
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      raw_reg <= '0;
    end else begin
      raw_reg <= gated_in;
    end
  end

  // software-visible pin value through the synchroniser
  ppo_pin_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_raw     (gated_in),
    .o_sync    (pin_input_sample_bit)
  );

  // sleep history for clamp release detection
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sleep_d_reg <= 1'h0;
      wake_reg    <= '0;
    end else begin
      sleep_d_reg <= i_sleep_clamp;
      wake_reg    <= wake_next;
    end
  end

  // read mux; strobes are one-hot by contract, direction wins on overlap
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= '0;
    end else if (i_read_direction_strobe) begin
      rdata_reg <= pin_direction_bit_reg;
    end else if (i_read_output_data_strobe) begin
      rdata_reg <= pin_output_data_bit_reg;
    end else if (i_read_pin_strobe) begin
      rdata_reg <= pin_input_sample_bit;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign o_pad_ctrl         = pad_reg;
  assign o_alt_fn_raw_input = raw_reg;
  assign o_ext_int_wake_set = wake_reg;
  assign o_rdata            = rdata_reg;

  // analog path is a pad-level wire outside this digital block

  // register-path pull-up never on while the driver is on
  property p_pu_excl;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      drv_en_next != '0 |=>
      (pad_reg.pullup_en & pad_reg.drive_en & ~$past(i_override.pullup_override_enable)) == '0;
  endproperty
  a_pu_excl: assert property (p_pu_excl) else $error("pullup with driver");

  // reset tri-states the next cycle
  property p_rst_tri;
    @(posedge i_sys_clk) !i_rst_n |=> (pad_reg.drive_en == '0 && pad_reg.pullup_en == '0);
  endproperty
  a_rst_tri: assert property (p_rst_tri) else $error("pins not tri-stated");

  // global disable kills non-overridden pull-ups
  property p_pud;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_global_pullup_disable && i_override.pullup_override_enable == '0
      |=> pad_reg.pullup_en == '0;
  endproperty
  a_pud: assert property (p_pud) else $error("pullup despite disable");

  // clamp zeroes raw input of non-interrupt, non-overridden pins
  property p_clamp;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_sleep_clamp && i_override.input_enable_override_enable == '0
      |=> (raw_reg & ~$past(i_ext_int_pin & i_ext_int_enable)) == '0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("input not clamped");

  // override pull-up follows its value, whether the driver is on or not
  property p_pu_ovr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_override.pullup_override_enable != '0 |=>
      (pad_reg.pullup_en & $past(i_override.pullup_override_enable)) ==
      $past(i_override.pullup_override_enable & i_override.pullup_override_value);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pullup ignores override");

  // driver enable from override value where enabled, else direction register
  property p_drv_en;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_override.direction_override_enable != '0 |=>
      pad_reg.drive_en == $past((i_override.direction_override_enable &
                                 i_override.direction_override_value) |
                                (~i_override.direction_override_enable &
                                 pin_direction_bit_reg));
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver enable wrong");

  // clamp release: clamp seen, then gone on the next edge
  sequence s_clamp_release;
    i_sleep_clamp ##1 !i_sleep_clamp;
  endsequence

  // wake flag only on async, disabled interrupt pins that were high at release
  property p_wake;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_clamp_release |=>
      (wake_reg & ~$past(i_ext_int_pin & i_ext_int_async & ~i_ext_int_enable & i_pad)) == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag on wrong pin");
endmodule // ppo_port

// *** tb_top.sv ***
// testbench for the port pin override logic
`timescale 1ns/1ps
module tb_top;
  logic       i_sys_clk = 1'h0;
  logic       i_rst_n = 1'h0;
  logic       sleep = 0, global_pullup_disable = 0, wr_d = 0, wr_dir = 0, rd_d = 0, rd_dir = 0, rd_pin = 0, alt = 0;
  logic [7:0] wdata = 0, ipin = 0, ien = 0, iasync = 0, ext_en = 0, ext_val = 0;
  logic [7:0] rdata, raw, wake, pad, acc;
  logic [1:0] sense [8] = '{default: 2'h0};
  ppo_pkg::ppo_override_type ov = '0;
  ppo_pkg::ppo_override_type ov_port;
  ppo_pkg::ppo_pad_ctrl_type pc;
  int         err_count = 0;
  int         comparisons = 0;
  // 100 MHz system clock
  always #5 i_sys_clk = ~i_sys_clk;
  ppo_port ppo_port_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sleep_clamp(sleep),
    .i_global_pullup_disable(global_pullup_disable), .i_write_output_data_strobe(wr_d),
    .i_write_direction_strobe(wr_dir), .i_read_output_data_strobe(rd_d),
    .i_read_direction_strobe(rd_dir), .i_read_pin_strobe(rd_pin), .i_wdata(wdata),
    .o_rdata(rdata), .i_override(ov_port), .o_alt_fn_raw_input(raw), .i_ext_int_pin(ipin),
    .i_ext_int_enable(ien), .i_ext_int_async(iasync), .i_ext_int_sense(sense),
    .o_ext_int_wake_set(wake), .i_pad(pad), .o_pad_ctrl(pc));
  ppo_far_side ppo_far_side_inst (.i_sys_clk(i_sys_clk), .i_alt_active(alt), .i_alt_vals(ov),
    .i_alt_fn_raw_input(raw), .o_override(ov_port), .o_alt_sync(), .i_pad_ctrl(pc),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  // compare and count
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // let registered outputs land, then look between edges
  task automatic settle(int n);
    tick(n);
    @(negedge i_sys_clk);
  endtask
  // register write: sel 0 data, 1 direction
  task automatic wr(logic sel, logic [7:0] v);
    @(posedge i_sys_clk);
    wr_d <= !sel;
    wr_dir <= sel;
    wdata <= v;
    @(posedge i_sys_clk);
    {wr_d, wr_dir} <= 2'h0;
  endtask
  // register read: sel 0 pin, 1 direction, 2 data; data stands one cycle
  task automatic rd(int sel, logic [7:0] exp);
    @(posedge i_sys_clk);
    rd_pin <= (sel == 0);
    rd_dir <= (sel == 1);
    rd_d <= (sel == 2);
    @(posedge i_sys_clk);
    {rd_pin, rd_dir, rd_d} <= 3'h0;
    @(negedge i_sys_clk);
    chk(rdata, exp);
  endtask
  task automatic results();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(2);
    i_rst_n <= 1'h1;
    // plain port: pins 3..0 out, 5,4 pulled up, 7,6 driven from outside
    ext_en <= 8'hC0;
    ext_val <= 8'h80;
    wr(0, 8'h33);
    wr(1, 8'h0F);
    settle(8);
    chk(pc.drive_en, 8'h0F);
    chk(pc.drive_val & pc.drive_en, 8'h03);
    chk(pc.pullup_en, 8'h30);
    chk(raw, 8'hB3);
    rd(1, 8'h0F);
    rd(2, 8'h33);
    rd(0, 8'hB3);
    tick(1);
    global_pullup_disable <= 1'h1;
    settle(3);
    chk(pc.pullup_en, 8'h00);
    $display("test plain port done");
    // overrides win over direction, data and global disable
    tick(1);
    ext_en <= 8'h00;
    alt <= 1'h1;
    ov <= '{8'h0F, 8'h05, 8'hFF, 8'hF0, 8'hC0, 8'h40, 8'h00, 8'h00};
    settle(3);
    chk(pc.drive_en, 8'hF0);
    chk(pc.drive_val & pc.drive_en, 8'h70);
    chk(pc.pullup_en & 8'h0F, 8'h05);
    chk(raw & 8'hF5, 8'h75);
    $display("test overrides done");
    // sleep clamp, interrupt pin 0 bypass, input-enable override
    tick(1);
    {alt, global_pullup_disable} <= 2'h0;
    {ext_en, ext_val, ipin, ien} <= {8'hFF, 8'hFF, 8'h01, 8'h01};
    wr(1, 8'h00);
    tick(1);
    sleep <= 1'h1;
    settle(3);
    chk(raw, 8'h01);
    tick(1);
    ien <= 8'h00;
    settle(3);
    chk(raw, 8'h00);
    tick(1);
    alt <= 1'h1;
    ov <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
    settle(3);
    chk(raw, 8'h80);
    tick(1);
    {alt, sleep} <= 2'h0;
    settle(3);
    chk(raw, 8'hFF);
    $display("test sleep clamp done");
    // clamp release on a high, disabled, asynchronous pin, every sense
    for (int s = 0; s < 4; s++) begin
      tick(1);
      iasync <= 8'h01;
      sense[0] <= 2'(s);
      sleep <= 1'h1;
      tick(3);
      sleep <= 1'h0;
      acc = 8'h00;
      repeat (4) begin
        @(negedge i_sys_clk);
        acc = acc | wake;
      end
      chk(acc, (2'(s) != ppo_pkg::SENSE_LOW) ? 8'h01 : 8'h00);
    end
    $display("test wake flag done");
    // pull-ups and drivers all off while reset is active
    tick(1);
    alt <= 1'h1;
    ext_en <= 8'hF0;
    ov <= '{8'hFF, 8'hF3, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    settle(3);
    chk(pc.pullup_en, 8'hF3);
    tick(1);
    i_rst_n <= 1'h0;
    settle(1);
    chk(pc.drive_en, 8'h00);
    chk(pc.pullup_en, 8'h00);
    $display("test reset done");
    results();
  end
endmodule // tb_top
